// >>> rtl/load_store_unit.sv
// load/store unit: decode, address, traps, memory beats and write-back
`timescale 1ns/1ps
`default_nettype none
module load_store_unit
  import lsu_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [31:0] instr,
  input wire logic [31:0] src_one_data,
  input wire logic [31:0] src_two_data,
  input wire logic [31:0] store_first_data,
  input wire logic [31:0] store_second_data,
  input wire logic supervisor_mode,
  input wire logic fpu_enable_bit,
  input wire logic cop_enable_bit,
  input wire logic fpu_present,
  input wire logic cop_present,
  input wire logic fpu_busy,
  input wire logic [4:0] next_src_one,
  input wire logic [4:0] next_src_two,
  output logic load_use_stall,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_asi,
  output size_t mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_fault,
  output logic wb_we,
  output logic wb_pair,
  output wb_file_t wb_file,
  output logic [4:0] wb_addr,
  output logic [31:0] wb_data_first,
  output logic [31:0] wb_data_second,
  output logic trap_valid,
  output trap_t trap_code,
  output logic done
);
  state_t state_reg;
  logic [5:0] op3;
  logic imm_sel;
  logic fmt_ok;
  logic dec_legal;
  logic dec_store;
  logic dec_alt;
  logic dec_signed;
  size_t dec_size;
  wb_file_t dec_file;
  trap_t dec_trap;
  logic [7:0] dec_asi;
  logic [31:0] eff_addr;
  logic misaligned;
  logic accept;
  logic beat_ok;
  size_t size_reg;
  logic signed_reg;
  logic [4:0] dest_reg;
  wb_file_t file_reg;
  logic [31:0] second_data_reg;
  logic [31:0] first_word_reg;

  // big-endian lane pick, right-justified, zero or sign filled
  function automatic logic [31:0] lane_extract(input logic [31:0] word, input logic [1:0] offs,
                                               input size_t sz, input logic sgn);
    logic [31:0] sh;
    sh = word;
    case (sz)
      SZ_BYTE: begin
        sh = word >> {~offs, 3'b000};
        return {{24{sgn & sh[7]}}, sh[7:0]};
      end
      SZ_HALF: begin
        sh = word >> {~offs[1], 4'b0000};
        return {{16{sgn & sh[15]}}, sh[15:0]};
      end
      default: return sh;
    endcase
  endfunction

  function automatic logic [31:0] store_trim(input logic [31:0] data, input size_t sz);
    case (sz)
      SZ_BYTE: return {{24{1'b0}}, data[7:0]};
      SZ_HALF: return {{16{1'b0}}, data[15:0]};
      default: return data;
    endcase
  endfunction

  // a pair destination matches on either register
  function automatic logic reads_dest(input logic [4:0] src, input logic [4:0] dest,
                                      input size_t sz);
    if (sz == SZ_DBL) begin
      return src[4:1] == dest[4:1];
    end
    return src == dest;
  endfunction

  assign op3 = instr[OP3_LSB +: 6];
  assign imm_sel = instr[IMM_BIT];
  assign fmt_ok = instr[FMT_LSB +: 2] == FMT_MEM;

  always_comb begin
    dec_legal = 1'b0;
    dec_store = 1'b0;
    dec_alt = 1'b0;
    dec_signed = 1'b0;
    dec_size = SZ_WORD;
    dec_file = WB_INT;
    if (fmt_ok && !op3[5]) begin
      dec_store = op3[2];
      dec_alt = op3[4];
      dec_signed = op3[3];
      dec_size = size_t'(op3[1:0]);
      dec_legal = !op3[3] || (!op3[2] && (op3[1:0] == 2'b01 || op3[1:0] == 2'b10));
    end else if (fmt_ok) begin
      dec_legal = 1'b1;
      case (op3)
        LOAD_FLOAT_SINGLE_OP: dec_file = WB_FP;
        LOAD_FLOAT_PAIR_OP: begin
          dec_file = WB_FP;
          dec_size = SZ_DBL;
        end
        LOAD_FLOAT_STATE_OP: dec_file = WB_FSR;
        LOAD_COP_SINGLE_OP: dec_file = WB_COP;
        LOAD_COP_PAIR_OP: begin
          dec_file = WB_COP;
          dec_size = SZ_DBL;
        end
        LOAD_COP_STATE_OP: dec_file = WB_CSR;
        default: dec_legal = 1'b0;
      endcase
    end
  end

  addr_gen u_addr_gen (
    .base_value(src_one_data),
    .index_value(src_two_data),
    .imm_sel(imm_sel),
    .imm_value(instr[12:0]),
    .access_size(dec_size),
    .eff_addr(eff_addr),
    .misaligned(misaligned)
  );

  // illegal outranks privileged, unit-off outranks alignment
  always_comb begin
    if (!dec_legal || (dec_alt && imm_sel)) begin
      dec_trap = TRAP_ILLEGAL;
    end else if (dec_alt && !supervisor_mode) begin
      dec_trap = TRAP_PRIVILEGED;
    end else if (op3[5:4] == 2'b10 && !(fpu_enable_bit && fpu_present)) begin
      dec_trap = TRAP_FPU_OFF;
    end else if (op3[5:4] == 2'b11 && !(cop_enable_bit && cop_present)) begin
      dec_trap = TRAP_COP_OFF;
    end else if (misaligned) begin
      dec_trap = TRAP_MISALIGNED;
    end else begin
      dec_trap = TRAP_NONE;
    end
  end

  assign dec_asi = dec_alt ? instr[ASI_LSB +: 8]
                           : (supervisor_mode ? SYSTEM_DATA_SPACE : USER_DATA_SPACE);

  assign issue_ready = state_reg == ST_IDLE;
  assign accept = issue_valid && issue_ready;
  assign mem_req = state_reg == ST_FIRST || state_reg == ST_SECOND;
  assign beat_ok = mem_req && mem_ack && !mem_fault;

  // interlock is optional; only integer loads in flight raise it
  assign load_use_stall = !issue_ready && !mem_we && file_reg == WB_INT &&
                          (reads_dest(next_src_one, dest_reg, size_reg) ||
                           reads_dest(next_src_two, dest_reg, size_reg));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept && dec_trap == TRAP_NONE) begin
            state_reg <= (dec_file == WB_FSR && fpu_busy) ? ST_DRAIN : ST_FIRST;
          end
        end
        ST_DRAIN: begin
          if (!fpu_busy) begin
            state_reg <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (mem_ack) begin
            state_reg <= (!mem_fault && size_reg == SZ_DBL) ? ST_SECOND : ST_IDLE;
          end
        end
        default: begin
          if (mem_ack) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // access descriptor, captured at issue
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_addr <= '0;
      mem_asi <= '0;
      mem_size <= SZ_WORD;
      mem_we <= 1'b0;
      mem_wdata <= '0;
      size_reg <= SZ_WORD;
      signed_reg <= 1'b0;
      dest_reg <= '0;
      file_reg <= WB_INT;
      second_data_reg <= '0;
    end else if (accept && dec_trap == TRAP_NONE) begin
      mem_addr <= eff_addr;
      mem_asi <= dec_asi;
      mem_size <= (dec_size == SZ_DBL) ? SZ_WORD : dec_size;
      mem_we <= dec_store;
      mem_wdata <= store_trim(store_first_data, dec_size);
      size_reg <= dec_size;
      signed_reg <= dec_signed;
      dest_reg <= instr[RD_LSB +: 5];
      file_reg <= dec_file;
      second_data_reg <= store_second_data;
    end else if (state_reg == ST_FIRST && beat_ok && size_reg == SZ_DBL) begin
      mem_addr <= mem_addr + WORD_STEP;
      mem_wdata <= second_data_reg;
    end
  end

  // first word of a pair is held back so a late fault writes nothing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      first_word_reg <= '0;
    end else if (state_reg == ST_FIRST && beat_ok) begin
      first_word_reg <= mem_rdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wb_we <= 1'b0;
      wb_pair <= 1'b0;
      wb_file <= WB_INT;
      wb_addr <= '0;
      wb_data_first <= '0;
      wb_data_second <= '0;
      done <= 1'b0;
    end else begin
      wb_we <= 1'b0;
      done <= 1'b0;
      if (state_reg == ST_FIRST && beat_ok && size_reg != SZ_DBL) begin
        done <= 1'b1;
        wb_we <= !mem_we;
        wb_pair <= 1'b0;
        wb_file <= file_reg;
        wb_addr <= dest_reg;
        wb_data_first <= lane_extract(mem_rdata, mem_addr[1:0], size_reg, signed_reg);
      end else if (state_reg == ST_SECOND && beat_ok) begin
        done <= 1'b1;
        wb_we <= !mem_we;
        wb_pair <= 1'b1;
        wb_file <= file_reg;
        wb_addr <= {dest_reg[4:1], 1'b0};
        wb_data_first <= first_word_reg;
        wb_data_second <= mem_rdata;
      end
    end
  end

  // faults suppress all write-back: no constant is ever written
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trap_valid <= 1'b0;
      trap_code <= TRAP_NONE;
    end else begin
      trap_valid <= 1'b0;
      if (accept && dec_trap != TRAP_NONE) begin
        trap_valid <= 1'b1;
        trap_code <= dec_trap;
      end else if (mem_req && mem_ack && mem_fault) begin
        trap_valid <= 1'b1;
        trap_code <= TRAP_DATA_ACCESS;
      end
    end
  end

  logic [31:0] exp_addr;
  assign exp_addr = imm_sel ? src_one_data + {{19{instr[12]}}, instr[12:0]} : src_one_data + src_two_data;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  ea_form_a: assert property (accept && dec_trap == TRAP_NONE |=> mem_addr == $past(exp_addr))
    else $error("effective address wrong");
  asi_alt_a: assert property (accept && dec_trap == TRAP_NONE && dec_alt |=> mem_asi == $past(dec_asi)
    && $past(!imm_sel))
    else $error("alternate space id wrong");
  asi_plain_a: assert property (accept && dec_trap == TRAP_NONE && !dec_alt |=>
    mem_asi == ($past(supervisor_mode) ? SYSTEM_DATA_SPACE : USER_DATA_SPACE))
    else $error("ordinary data space wrong");
  misalign_a: assert property (accept && fmt_ok && op3 == LOAD_WORD_OP && |eff_addr[1:0] |=>
    trap_valid && trap_code == TRAP_MISALIGNED && !mem_req)
    else $error("misaligned word load not trapped");
  fault_nowrite_a: assert property (trap_valid |-> !wb_we && !done)
    else $error("write-back alongside trap");
  pair_second_a: assert property (state_reg == ST_SECOND |-> mem_addr[2:0] == 3'b100
    && $past(state_reg) != ST_IDLE)
    else $error("second beat address wrong");
  illegal_alt_a: assert property (accept && fmt_ok && !op3[5] && op3[4] && imm_sel |=>
    trap_valid && trap_code == TRAP_ILLEGAL)
    else $error("alternate with immediate not illegal");
  drain_wait_a: assert property (mem_req && file_reg == WB_FSR && !mem_we |-> !fpu_busy
    || $past(state_reg) == ST_FIRST)
    else $error("state load issued while float busy");
  fpu_off_a: assert property (accept && fmt_ok && op3 == LOAD_FLOAT_SINGLE_OP && !fpu_enable_bit |=>
    trap_valid && trap_code == TRAP_FPU_OFF ##1 !mem_req)
    else $error("disabled float load not trapped");
  cop_off_a: assert property (accept && fmt_ok && op3 == LOAD_COP_PAIR_OP && !cop_present |=>
    trap_code == TRAP_COP_OFF)
    else $error("absent coprocessor load not trapped");
  byte_store_a: assert property (mem_req && mem_we && mem_size == SZ_BYTE |-> mem_wdata[31:8] == '0)
    else $error("byte store carries upper bits");

  pair_load_c: cover property (state_reg == ST_SECOND && beat_ok && !mem_we ##1 wb_pair);
  drain_c: cover property (state_reg == ST_DRAIN ##1 state_reg == ST_FIRST);
  late_fault_c: cover property (state_reg == ST_SECOND && mem_ack && mem_fault);
  priv_c: cover property (trap_valid && trap_code == TRAP_PRIVILEGED);
endmodule
`default_nettype wire

// >>> rtl/lsu_pkg.sv
// constants, field positions and types shared by the load/store unit
package lsu_pkg;
  localparam logic [1:0] FMT_MEM = 2'b11;
  localparam int FMT_LSB = 30;
  localparam int RD_LSB = 25;
  localparam int OP3_LSB = 19;
  localparam int RS1_LSB = 14;
  localparam int IMM_BIT = 13;
  localparam int ASI_LSB = 5;
  localparam logic [5:0] LOAD_FLOAT_SINGLE_OP = 6'h20;
  localparam logic [5:0] LOAD_FLOAT_PAIR_OP = 6'h23;
  localparam logic [5:0] LOAD_FLOAT_STATE_OP = 6'h21;
  localparam logic [5:0] LOAD_COP_SINGLE_OP = 6'h30;
  localparam logic [5:0] LOAD_COP_PAIR_OP = 6'h33;
  localparam logic [5:0] LOAD_COP_STATE_OP = 6'h31;
  localparam logic [5:0] LOAD_WORD_OP = 6'h00;
  localparam logic [5:0] WRITE_WORD_OP = 6'h04;
  // data space codes for ordinary accesses, arbitrary values
  localparam logic [7:0] USER_DATA_SPACE = 8'h10;
  localparam logic [7:0] SYSTEM_DATA_SPACE = 8'h11;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // encoding matches the two low opcode bits of integer accesses
  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_HALF = 2'b10,
    SZ_DBL = 2'b11
  } size_t;
  typedef enum logic [2:0] {
    TRAP_NONE = 3'h0,
    TRAP_ILLEGAL = 3'h1,
    TRAP_PRIVILEGED = 3'h2,
    TRAP_MISALIGNED = 3'h3,
    TRAP_FPU_OFF = 3'h4,
    TRAP_COP_OFF = 3'h5,
    TRAP_DATA_ACCESS = 3'h6
  } trap_t;
  typedef enum logic [2:0] {
    WB_INT = 3'h0,
    WB_FP = 3'h1,
    WB_FSR = 3'h2,
    WB_COP = 3'h3,
    WB_CSR = 3'h4
  } wb_file_t;
  // single-beat path idle-first-idle flips one bit each way
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b11,
    ST_DRAIN = 2'b10
  } state_t;
endpackage

// >>> rtl/addr_gen.sv
// effective address adder and alignment check
`timescale 1ns/1ps
`default_nettype none
module addr_gen
  import lsu_pkg::*;
(
  input wire logic [31:0] base_value,
  input wire logic [31:0] index_value,
  input wire logic imm_sel,
  input wire logic [12:0] imm_value,
  input wire size_t access_size,
  output logic [31:0] eff_addr,
  output logic misaligned
);
  assign eff_addr = imm_sel ? base_value + {{19{imm_value[12]}}, imm_value}
                            : base_value + index_value;

  // byte accesses never misalign
  always_comb begin
    case (access_size)
      SZ_HALF: misaligned = eff_addr[0];
      SZ_WORD: misaligned = |eff_addr[1:0];
      SZ_DBL: misaligned = |eff_addr[2:0];
      default: misaligned = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/mem_model.sv
// memory system model: acks each beat after a random wait, faults one chosen address
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic fault_en,
  input wire logic [31:0] fault_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_fault
);
  integer seed = 63;
  logic [1:0] wait_reg = 2'h0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    mem_fault = 1'b0;
  end
  always @(posedge core_clk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      // released data must never look like the last word
      mem_rdata <= ~mem_rdata;
      wait_reg <= 2'($random(seed));
    end else if (mem_req && wait_reg == 2'h0) begin
      mem_ack <= 1'b1;
      // raw word; its meaning is up to the attached unit
      mem_rdata <= {mem_addr[31:2], 2'b00} ^ 32'h5a5a_c3c3;
      mem_fault <= fault_en && mem_addr == fault_addr;
    end else begin
      if (mem_req) wait_reg <= wait_reg - 2'h1;
      mem_rdata <= mem_rdata + 32'h1357_9bdf;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// random memory-access instructions checked against a bench model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lsu_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic issue_valid = 1'b0, supervisor_mode = 1'b0, fpu_enable_bit = 1'b0, cop_enable_bit = 1'b0;
  logic fpu_present = 1'b0, cop_present = 1'b0, fpu_busy = 1'b0, fault_en = 1'b0;
  logic [31:0] instr = '0, src_one_data = '0, src_two_data = '0, store_first_data = '0;
  logic [31:0] store_second_data = '0, fault_addr = '0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, wb_data_first, wb_data_second;
  logic [4:0] next_src_one = '0, next_src_two = '0, wb_addr;
  logic issue_ready, load_use_stall, mem_req, mem_we, mem_ack, mem_fault, wb_we, wb_pair, trap_valid, done;
  logic [7:0] mem_asi;
  size_t mem_size;
  wb_file_t wb_file;
  trap_t trap_code;
  integer seed = 63;
  int n_fail = 0;
  int check_count = 0;
  // every decoded opcode plus a few undecoded ones
  logic [5:0] ops [30] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h09, 6'h0a, 6'h10, 6'h11, 6'h12, 6'h13,
    6'h19, 6'h1a, 6'h04, 6'h05, 6'h06, 6'h07, 6'h14, 6'h15, 6'h16, 6'h17,
    6'h20, 6'h21, 6'h23, 6'h30, 6'h31, 6'h33, 6'h0d, 6'h24, 6'h35, 6'h3f};

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  load_store_unit DUT (.core_clk(core_clk), .reset(reset), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .instr(instr), .src_one_data(src_one_data), .src_two_data(src_two_data),
    .store_first_data(store_first_data), .store_second_data(store_second_data),
    .supervisor_mode(supervisor_mode), .fpu_enable_bit(fpu_enable_bit), .cop_enable_bit(cop_enable_bit),
    .fpu_present(fpu_present), .cop_present(cop_present), .fpu_busy(fpu_busy),
    .next_src_one(next_src_one), .next_src_two(next_src_two), .load_use_stall(load_use_stall),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_asi(mem_asi), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault),
    .wb_we(wb_we), .wb_pair(wb_pair), .wb_file(wb_file), .wb_addr(wb_addr),
    .wb_data_first(wb_data_first), .wb_data_second(wb_data_second), .trap_valid(trap_valid),
    .trap_code(trap_code), .done(done));

  mem_model memory (.core_clk(core_clk), .mem_req(mem_req), .mem_addr(mem_addr), .fault_en(fault_en),
    .fault_addr(fault_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_trap(input trap_t got, input trap_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: trap got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic run_one();
    logic [31:0] ins, s1, s2, ea, w0, d1, d2, msk, am, da, db;
    logic [5:0] op3;
    logic [4:0] rd, ra, rb, n1, n2;
    logic [1:0] sc;
    logic alt, dbl, st, ld, sup, fe, cp, hit, fin;
    int cls, fb, nb, k, cyc;
    trap_t tr, xt;
    wb_file_t ef;
    begin
      ins = $random(seed);
      op3 = ops[{$random(seed)} % 30];
      ins[31:30] = FMT_MEM;
      ins[24:19] = op3;
      s1 = $random(seed);
      s2 = $random(seed);
      ea = s1 + (ins[IMM_BIT] ? {{19{ins[12]}}, ins[12:0]} : s2);
      // half the time force alignment, otherwise nearly all wide accesses trap
      if ($random(seed) & 1) begin
        s1 = s1 - {29'h0, ea[2:0]};
        ea = {ea[31:3], 3'h0};
      end
      sup = 1'($random(seed));
      fe = ($random(seed) & 7) != 0;
      cp = ($random(seed) & 7) != 0;
      rd = ins[29:25];
      sc = op3[1:0];
      dbl = sc == 2'b11;
      alt = !op3[5] && op3[4];
      if (!op3[5]) cls = (op3[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha}) ? 0 :
        (op3[3:0] inside {4'h4, 4'h5, 4'h6, 4'h7}) ? 1 : 4;
      else cls = (op3[3:0] inside {4'h0, 4'h1, 4'h3}) ? (op3[4] ? 3 : 2) : 4;
      st = cls == 1;
      ld = cls == 0 || cls == 2 || cls == 3;
      am = dbl ? 7 : (cls > 1 || sc == 2'b00) ? 3 : sc == 2'b10 ? 1 : 0;
      if (cls == 4 || (alt && ins[IMM_BIT])) tr = TRAP_ILLEGAL;
      else if (alt && !sup) tr = TRAP_PRIVILEGED;
      else if (cls == 2 && !(fe && ins[0])) tr = TRAP_FPU_OFF;
      else if (cls == 3 && !(cp && ins[1])) tr = TRAP_COP_OFF;
      else if ((ea & am) != 0) tr = TRAP_MISALIGNED;
      else tr = TRAP_NONE;
      fb = (tr == TRAP_NONE && ($random(seed) & 7) == 0) ? (dbl ? ($random(seed) & 1) : 0) : -1;
      nb = (tr != TRAP_NONE) ? 0 : (fb >= 0) ? fb + 1 : dbl ? 2 : 1;
      xt = (tr != TRAP_NONE) ? tr : (fb >= 0) ? TRAP_DATA_ACCESS : TRAP_NONE;
      w0 = {ea[31:2], 2'b00} ^ 32'h5a5a_c3c3;
      d2 = (ea + WORD_STEP) ^ 32'h5a5a_c3c3;
      d1 = w0;
      if (cls == 0 && sc == 2'b01) begin
        d1 = w0 >> (8 * (3 - ea[1:0]));
        d1 = {{24{d1[7] & op3[3]}}, d1[7:0]};
      end
      if (cls == 0 && sc == 2'b10) begin
        d1 = w0 >> (16 * (1 - ea[1]));
        d1 = {{16{d1[15] & op3[3]}}, d1[15:0]};
      end
      da = $random(seed);
      db = $random(seed);
      msk = sc == 2'b01 ? 32'h0000_00ff : sc == 2'b10 ? 32'h0000_ffff : 32'hffff_ffff;
      ef = cls == 0 ? WB_INT : cls == 2 ? (sc == 2'b01 ? WB_FSR : WB_FP) : (sc == 2'b01 ? WB_CSR : WB_COP);
      ra = dbl ? {rd[4:1], 1'b0} : rd;
      rb = dbl ? {rd[4:1], 1'b1} : rd;
      n1 = seed[0] ? rb : 5'($random(seed));
      n2 = 5'($random(seed));
      hit = cls == 0 && (n1 == ra || n1 == rb || n2 == ra || n2 == rb);
      @(posedge core_clk);
      issue_valid <= 1'b1;
      instr <= ins;
      src_one_data <= s1;
      src_two_data <= s2;
      store_first_data <= da;
      store_second_data <= db;
      supervisor_mode <= sup;
      fpu_enable_bit <= fe;
      cop_enable_bit <= cp;
      fpu_present <= ins[0];
      cop_present <= ins[1];
      fpu_busy <= cls == 2 && sc == 2'b01;
      next_src_one <= n1;
      next_src_two <= n2;
      fault_en <= fb >= 0;
      fault_addr <= ea + 32'(4 * fb);
      @(posedge core_clk);
      issue_valid <= 1'b0;
      instr <= ~ins;
      k = 0;
      fin = 1'b0;
      for (cyc = 0; cyc < 60 && !fin; cyc++) begin
        @(negedge core_clk);
        if (fpu_busy) chk(mem_req, 1'b0, "beat while float busy");
        if (mem_req) chk(load_use_stall, hit, "stall");
        if (mem_req && mem_ack) begin
          chk(mem_addr, ea + 32'(4 * k), "address");
          chk(mem_asi, alt ? ins[12:5] : sup ? SYSTEM_DATA_SPACE : USER_DATA_SPACE,
              "space");
          chk(mem_size, (cls > 1 || dbl) ? SZ_WORD : sc, "size");
          chk(mem_we, st, "direction");
          if (st) chk(mem_wdata & msk, (k == 0 ? da : db) & msk, "store data");
          k++;
        end
        if (trap_valid || done) begin
          fin = 1'b1;
          chk(32'(k), 32'(nb), "beat count");
          chk_trap(trap_valid ? trap_code : TRAP_NONE, xt);
          chk(done, xt == TRAP_NONE, "completion");
          chk(wb_we, ld && xt == TRAP_NONE, "write-back");
          if (ld && xt == TRAP_NONE) begin
            chk(wb_file, ef, "file");
            chk(wb_pair, dbl, "pair");
            if (sc != 2'b01 || cls == 0) chk(wb_addr, ra, "dest");
            chk(wb_data_first, d1, "first word");
            if (dbl) chk(wb_data_second, d2, "second word");
          end
        end
        @(posedge core_clk);
        if (cyc == 3) fpu_busy <= 1'b0;
      end
      if (!fin) begin
        n_fail++;
        results();
      end
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(issue_ready, 1'b1, "ready after reset");
    chk(mem_req, 1'b0, "idle after reset");
    repeat (300) run_one();
    // mid-run reset: the unit must fall back to idle with no stray pulse
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(issue_ready, 1'b1, "ready after second reset");
    chk(mem_req, 1'b0, "idle after second reset");
    chk(trap_valid | done | wb_we, 1'b0, "pulses after second reset");
    repeat (300) run_one();
    results();
  end
endmodule
`default_nettype wire
